// File: rtl/npic_pkg.sv
// Shared constants and types of the prioritized vectored interrupt controller.
// Assumes one 10 MHz clock and an active-low asynchronous reset in the user.
// What this block does
// - Clearing enable stops source, peripheral enables untouched
// - Setting enable lets source reach processor
// - Enable readback is non-zero when enabled
// - Global gate blocks request, keeps source enables
// - Gate change reports its previous state
// - Clear-pending drops recorded, unserviced requests
// - Set-pending dispatches when priorities allow
// - Only enabled pending sources dispatch; disabled stay pending
// - Grouping splits preemption/sub bits; 3..7 same
// - Grouping readback gives preemption bit count
// - Nonzero mask blocks priority at or above threshold
// - Mask 4 passes levels 0-3 only
// - Only upper three priority bits used
// - Smaller priority number is more urgent
// - Most urgent simultaneous request goes first
// - Accepted source gets its vector table address
// - Vector base relocatable, 1 kB aligned only
// - Each source holds an 8-bit priority field
// - Ties go to lower interrupt number
// - Equal preemption level never preempts, tail-chains
// - Up to 154 sources, eight levels
package npic_pkg;

   // ****************************************
   // Sizes
   // ****************************************
   localparam int NUM_SRC = 154;
   localparam int ID_W = 8;
   localparam int PRIO_W = 8;
   localparam int LVL_W = 3;
   localparam int LVL_LSB = PRIO_W - LVL_W;
   localparam int NUM_LVL = 8;

   // ****************************************
   // Vector table
   // ****************************************
   localparam logic [31:0] VTOR_ALIGN_MASK = 32'hFFFFFC00;
   localparam logic [31:0] VTOR_RST = 32'h00000000;
   localparam logic [ID_W-1:0] VEC_IDX_OFS = 8'h10;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [LVL_W-1:0] GRP_RST = 3'h0;
   localparam logic [LVL_W-1:0] MASK_RST = 3'h0;
   localparam logic GATE_OPEN_RST = 1'b1;
   localparam logic [PRIO_W-1:0] PRIO_RST = 8'h00;

   typedef enum logic [3:0] {
      NPIC_OP_ENABLE,
      NPIC_OP_DISABLE,
      NPIC_OP_IS_ENABLED,
      NPIC_OP_GATE_OPEN,
      NPIC_OP_GATE_CLOSE,
      NPIC_OP_PEND_CLR,
      NPIC_OP_PEND_SET,
      NPIC_OP_PRIO_SET,
      NPIC_OP_PRIO_GET,
      NPIC_OP_GRP_SET,
      NPIC_OP_GRP_GET,
      NPIC_OP_MASK_SET,
      NPIC_OP_MASK_GET,
      NPIC_OP_VTOR_SET,
      NPIC_OP_VTOR_GET
   } npic_op_t;

   typedef struct packed {
      logic valid;
      npic_op_t op;
      logic [ID_W-1:0] id;
      logic [31:0] data;
   } npic_cmd_t;

   typedef struct packed {
      logic req;
      logic [ID_W-1:0] id;
      logic [31:0] vec_addr;
   } npic_irq_t;

   typedef struct packed {
      logic [NUM_SRC-1:0] en;
      logic [NUM_SRC-1:0] pend;
      logic [NUM_SRC-1:0] src_prev;
      logic [NUM_SRC-1:0][PRIO_W-1:0] prio;
      logic [NUM_LVL-1:0] act;
      logic [LVL_W-1:0] grp;
      logic [LVL_W-1:0] mask;
      logic gate_open;
      logic [31:0] vtor;
      logic rd_valid;
      logic [31:0] rd_data;
      npic_irq_t irq;
   } npic_state_t;

endpackage

// File: rtl/npic_top.sv
// Prioritized vectored interrupt controller: pending, enables, arbitration,
// preemption tracking and vector address. Assumes the core acknowledges the
// presented request and signals completion of the innermost handler.
`timescale 1ns/1ns
module npic_top (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [npic_pkg::NUM_SRC-1:0] src_irq_in,
   input wire npic_pkg::npic_cmd_t cmd_in,
   input wire logic cpu_ack_in,
   input wire logic cpu_eoi_in,
   output npic_pkg::npic_irq_t irq_out,
   output logic rd_valid_out,
   output logic [31:0] rd_data_out
);

   // ****************************************
   // Helpers
   // ****************************************
   // Preemption bits kept; grouping 3..7 all clamp to 3
   function automatic logic [1:0] pre_bits(input logic [npic_pkg::LVL_W-1:0] g);
      pre_bits = (g >= 3'h3) ? 2'h3 : g[1:0];
   endfunction

   // Preemption group of a level: sub-priority bits zeroed
   function automatic logic [npic_pkg::LVL_W-1:0] pre_grp(
      input logic [npic_pkg::LVL_W-1:0] lvl,
      input logic [npic_pkg::LVL_W-1:0] g
   );
      logic [npic_pkg::LVL_W-1:0] keep;
      keep = ~(3'h7 >> pre_bits(g));
      pre_grp = lvl & keep;
   endfunction

   // Lowest set active bit is the running (most urgent) group
   function automatic logic [npic_pkg::LVL_W-1:0] low_idx(input logic [npic_pkg::NUM_LVL-1:0] a);
      logic [npic_pkg::LVL_W-1:0] r;
      r = 3'h0;
      for (int k = npic_pkg::NUM_LVL - 1; k >= 0; k--) begin
         if (a[k]) begin
            r = 3'(k);
         end
      end
      low_idx = r;
   endfunction

   npic_pkg::npic_state_t s_r;
   npic_pkg::npic_state_t s_nxt;

   // ****************************************
   // Per-source eligibility and edge capture
   // ****************************************
   logic [npic_pkg::NUM_SRC-1:0] elig;
   logic [npic_pkg::NUM_SRC-1:0] src_rise;

   genvar gi;
   generate
      for (gi = 0; gi < npic_pkg::NUM_SRC; gi++) begin : g_src
         logic [npic_pkg::LVL_W-1:0] lvl;
         assign lvl = s_r.prio[gi][npic_pkg::PRIO_W-1:npic_pkg::LVL_LSB];
         // Masked when level >= threshold; threshold 0 masks nothing
         assign elig[gi] = s_r.pend[gi] & s_r.en[gi]
                         & ((s_r.mask == 3'h0) | (lvl < s_r.mask));
         assign src_rise[gi] = src_irq_in[gi] & ~s_r.src_prev[gi];
      end
   endgenerate

   // ****************************************
   // Arbitration
   // ****************************************
   logic found;
   logic [npic_pkg::ID_W-1:0] best_id;
   logic [npic_pkg::LVL_W-1:0] best_lvl;

   always_comb begin
      found = 1'b0;
      best_id = 8'h00;
      best_lvl = 3'h7;
      // Walk downward with <= so equal levels end on the lowest number
      for (int i = npic_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (elig[i] && (!found || s_r.prio[i][npic_pkg::PRIO_W-1:npic_pkg::LVL_LSB] <= best_lvl)) begin
            found = 1'b1;
            best_id = 8'(i);
            best_lvl = s_r.prio[i][npic_pkg::PRIO_W-1:npic_pkg::LVL_LSB];
         end
      end
   end

   // ****************************************
   // Next state
   // ****************************************
   logic cmd_id_ok;
   logic ack_ok;
   logic can_preempt;
   logic [npic_pkg::LVL_W-1:0] ack_grp;
   logic [npic_pkg::LVL_W-1:0] best_grp;
   logic [npic_pkg::NUM_LVL-1:0] act_tmp;
   logic [npic_pkg::ID_W-1:0] cid;
   logic [npic_pkg::LVL_W-1:0] ack_lvl;

   always_comb begin
      s_nxt = s_r;
      cid = cmd_in.id;
      cmd_id_ok = cmd_in.valid && (cmd_in.id < 8'(npic_pkg::NUM_SRC));
      ack_lvl = s_r.prio[s_r.irq.id][npic_pkg::PRIO_W-1:npic_pkg::LVL_LSB];
      ack_grp = pre_grp(ack_lvl, s_r.grp);
      best_grp = pre_grp(best_lvl, s_r.grp);
      // A stale presentation is refused: the source must still qualify
      ack_ok = cpu_ack_in && s_r.irq.req && elig[s_r.irq.id];
      s_nxt.rd_valid = 1'b0;
      s_nxt.src_prev = src_irq_in;

      // Handler completion pops the innermost group, then acceptance pushes
      act_tmp = s_r.act;
      if (cpu_eoi_in) begin
         act_tmp = s_r.act & (s_r.act - 8'h01);
      end
      if (ack_ok) begin
         act_tmp[ack_grp] = 1'b1;
         s_nxt.pend[s_r.irq.id] = 1'b0;
      end
      s_nxt.act = act_tmp;

      if (cmd_in.valid) begin
         case (cmd_in.op)
            npic_pkg::NPIC_OP_ENABLE: begin
               if (cmd_id_ok) begin
                  s_nxt.en[cid] = 1'b1;
               end
            end
            npic_pkg::NPIC_OP_DISABLE: begin
               if (cmd_id_ok) begin
                  s_nxt.en[cid] = 1'b0;
               end
            end
            npic_pkg::NPIC_OP_IS_ENABLED: begin
               s_nxt.rd_valid = 1'b1;
               s_nxt.rd_data = {31'h00000000, cmd_id_ok & s_r.en[cid]};
            end
            npic_pkg::NPIC_OP_GATE_OPEN: begin
               s_nxt.gate_open = 1'b1;
               s_nxt.rd_valid = 1'b1;
               s_nxt.rd_data = {31'h00000000, ~s_r.gate_open};
            end
            npic_pkg::NPIC_OP_GATE_CLOSE: begin
               s_nxt.gate_open = 1'b0;
               s_nxt.rd_valid = 1'b1;
               s_nxt.rd_data = {31'h00000000, ~s_r.gate_open};
            end
            npic_pkg::NPIC_OP_PEND_CLR: begin
               if (cmd_id_ok) begin
                  s_nxt.pend[cid] = 1'b0;
               end
            end
            npic_pkg::NPIC_OP_PRIO_SET: begin
               if (cmd_id_ok) begin
                  s_nxt.prio[cid] = cmd_in.data[npic_pkg::PRIO_W-1:0];
               end
            end
            npic_pkg::NPIC_OP_PRIO_GET: begin
               s_nxt.rd_valid = 1'b1;
               // Unknown source reads as all ones, the signed -1
               s_nxt.rd_data = cmd_id_ok ? {24'h000000, s_r.prio[cid]} : 32'hFFFFFFFF;
            end
            npic_pkg::NPIC_OP_GRP_SET: begin
               s_nxt.grp = (cmd_in.data > 32'h00000007) ? 3'h7 : cmd_in.data[2:0];
            end
            npic_pkg::NPIC_OP_GRP_GET: begin
               s_nxt.rd_valid = 1'b1;
               s_nxt.rd_data = {30'h00000000, pre_bits(s_r.grp)};
            end
            npic_pkg::NPIC_OP_MASK_SET: begin
               s_nxt.mask = (cmd_in.data > 32'h00000007) ? 3'h7 : cmd_in.data[2:0];
            end
            npic_pkg::NPIC_OP_MASK_GET: begin
               s_nxt.rd_valid = 1'b1;
               s_nxt.rd_data = {29'h00000000, s_r.mask};
            end
            npic_pkg::NPIC_OP_VTOR_SET: begin
               // Low bits dropped: the table only lives on 1 kB boundaries
               s_nxt.vtor = cmd_in.data & npic_pkg::VTOR_ALIGN_MASK;
            end
            npic_pkg::NPIC_OP_VTOR_GET: begin
               s_nxt.rd_valid = 1'b1;
               s_nxt.rd_data = s_r.vtor;
            end
            default: begin
            end
         endcase
      end

      // Hardware and software sets win over any clear in the same cycle
      for (int j = 0; j < npic_pkg::NUM_SRC; j++) begin
         if (src_rise[j]) begin
            s_nxt.pend[j] = 1'b1;
         end
      end
      if (cmd_id_ok && cmd_in.op == npic_pkg::NPIC_OP_PEND_SET) begin
         s_nxt.pend[cid] = 1'b1;
      end

      // Strictly more urgent group needed; equal groups wait for tail chain
      can_preempt = (s_r.act == 8'h00) || (best_grp < low_idx(s_r.act));
      s_nxt.irq.req = s_r.gate_open && found && can_preempt && !ack_ok;
      s_nxt.irq.id = best_id;
      s_nxt.irq.vec_addr = s_r.vtor + {22'h000000, best_id + npic_pkg::VEC_IDX_OFS, 2'h0};
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_r.en <= '0;
         s_r.pend <= '0;
         s_r.src_prev <= '0;
         s_r.prio <= {npic_pkg::NUM_SRC{npic_pkg::PRIO_RST}};
         s_r.act <= 8'h00;
         s_r.grp <= npic_pkg::GRP_RST;
         s_r.mask <= npic_pkg::MASK_RST;
         s_r.gate_open <= npic_pkg::GATE_OPEN_RST;
         s_r.vtor <= npic_pkg::VTOR_RST;
         s_r.rd_valid <= 1'b0;
         s_r.rd_data <= 32'h00000000;
         s_r.irq <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign irq_out = s_r.irq;
   assign rd_valid_out = s_r.rd_valid;
   assign rd_data_out = s_r.rd_data;

endmodule

// File: testbench/npic_assertions.sv
// Port-level checks on the interrupt controller.
// Bound to npic_top; one clock, active-low asynchronous reset.
`timescale 1ns/1ns
module npic_assertions (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire npic_pkg::npic_cmd_t cmd_in,
   input wire logic cpu_ack_in,
   input wire npic_pkg::npic_irq_t irq_out,
   input wire logic rd_valid_out,
   input wire logic [31:0] rd_data_out
);
   // ****
   // Properties
   // ****
   logic [14:0] hot;
   // Bit n flags command code n; 15'h551C marks the read codes
   assign hot = cmd_in.valid ? 15'h0001 << cmd_in.op : 15'h0000;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!nrst_in);
   property p_rd_lat;
      1'b1 |=> rd_valid_out == $past(|(hot & 15'h551C));
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("answer pulse timing wrong");
   property p_gate_blk;
      hot[4] |-> ##2 !irq_out.req;
   endproperty
   a_gate_blk: assert property (p_gate_blk) else $error("request passed a closed gate");
   property p_prev_gate;
      hot[4] ##1 (hot[3] || hot[4]) |=> rd_data_out[0];
   endproperty
   a_prev_gate: assert property (p_prev_gate) else $error("prior gate state lost");
   property p_en;
      hot[0] && cmd_in.id < npic_pkg::NUM_SRC ##1 hot[2] && cmd_in.id == $past(cmd_in.id) |=> rd_data_out != 32'h0;
   endproperty
   a_en: assert property (p_en) else $error("enable not reported");
   property p_grp;
      hot[9] ##1 hot[10] |=> rd_data_out == ($past(cmd_in.data, 2) > 32'h2 ? 32'h3 : $past(cmd_in.data, 2));
   endproperty
   a_grp: assert property (p_grp) else $error("grouping readback wrong");
   property p_vtor;
      hot[13] ##1 hot[14] |=> rd_data_out == ($past(cmd_in.data, 2) & npic_pkg::VTOR_ALIGN_MASK);
   endproperty
   a_vtor: assert property (p_vtor) else $error("table base not aligned");
   property p_vec;
      irq_out.req |-> irq_out.vec_addr[9:0] == {irq_out.id + 8'h10, 2'b00};
   endproperty
   a_vec: assert property (p_vec) else $error("vector address wrong");
   property p_ack;
      cpu_ack_in && irq_out.req |=> !irq_out.req;
   endproperty
   a_ack: assert property (p_ack) else $error("request held after accept");
   c_ack: cover property (cpu_ack_in && irq_out.req);
   c_gate: cover property (hot[4] ##1 hot[3]);
   c_vtor: cover property (hot[13] ##1 hot[14]);
endmodule

// File: testbench/npic_core_model.sv
// Behavioural core: accepts presented requests and ends handlers.
// Shares the controller clock and active-low reset.
`timescale 1ns/1ns
module npic_core_model (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire npic_pkg::npic_irq_t irq_in,
   input wire logic [1:0] dly_in,
   input wire logic hold_in,
   output logic ack_out,
   output logic eoi_out,
   output logic taken_out
);
   // ****
   // Accept and completion
   // ****
   logic [1:0] cnt_r;
   logic [3:0] depth_r;
   wire go = irq_in.req && !ack_out && cnt_r >= dly_in;
   assign taken_out = ack_out & irq_in.req;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ack_out <= 1'b0;
         eoi_out <= 1'b0;
         cnt_r <= 2'h0;
         depth_r <= 4'h0;
      end else begin
         ack_out <= go;
         cnt_r <= (irq_in.req && !go && cnt_r != 2'h3) ? cnt_r + 2'h1 : 2'h0;
         // Completion never shares an edge with an accept, so nesting stays unambiguous
         eoi_out <= depth_r != 4'h0 && !hold_in && !eoi_out && !go && !ack_out;
         depth_r <= depth_r + {3'h0, taken_out} - {3'h0, eoi_out};
      end
   end
endmodule

// File: testbench/npic_tb.sv
// Self-checking bench: commands and sources driven here, core side by a model.
// Assumes the package, the top and the verification modules are compiled first.
`timescale 1ns/1ns
module testbench;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic hold = 1'b0;
   logic [1:0] dly = 2'h0;
   logic [153:0] src = '0;
   npic_pkg::npic_cmd_t cmd = '0;
   npic_pkg::npic_irq_t irq;
   logic ack, eoi, rv, taken;
   logic [31:0] rdat, r, vtor = 32'h0;
   logic [7:0] id;
   logic [31:0] exp_rd[$];
   logic [7:0] exp_id[$];
   int n_errors = 0;
   int check_count = 0;
   always #50 clk_in = ~clk_in;
   npic_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .src_irq_in(src), .cmd_in(cmd), .cpu_ack_in(ack),
      .cpu_eoi_in(eoi), .irq_out(irq), .rd_valid_out(rv), .rd_data_out(rdat));
   npic_core_model core (.clk_in(clk_in), .nrst_in(nrst_in), .irq_in(irq), .dly_in(dly), .hold_in(hold),
      .ack_out(ack), .eoi_out(eoi), .taken_out(taken));
   // ****
   // Tasks
   // ****
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input npic_pkg::npic_op_t op, input logic [7:0] i, input logic [31:0] d);
      @(posedge clk_in);
      cmd <= '{1'b1, op, i, d};
   endtask
   task automatic rd(input npic_pkg::npic_op_t op, input logic [7:0] i, input logic [31:0] e);
      wr(op, i, 32'h0);
      exp_rd.push_back(e);
   endtask
   task automatic idle(input int n);
      @(posedge clk_in);
      cmd.valid <= 1'b0;
      repeat (n) @(posedge clk_in);
   endtask
   // One-cycle pulse: only the rising edge pends a source
   task automatic raise(input logic [153:0] m);
      @(posedge clk_in);
      src <= m;
      @(posedge clk_in);
      src <= '0;
   endtask
   // Three chained handlers with the longest accept delay need about 30 cycles
   task automatic drained;
      idle(40);
      check("queued irq", 32'(exp_id.size()), 32'h0);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ****
   // Result watcher and watchdog
   // ****
   always @(posedge clk_in) begin
      if (rv === 1'b1) check("read data", rdat, exp_rd.size() ? exp_rd.pop_front() : 32'hDEADBEEF);
      if (taken === 1'b1 && exp_id.size() == 0) check("unexpected irq", {24'h0, irq.id}, 32'hFFFFFFFF);
      else if (taken === 1'b1) begin
         check("vector", irq.vec_addr, vtor + {22'h0, exp_id[0] + 8'h10, 2'b00});
         check("irq id", {24'h0, irq.id}, {24'h0, exp_id.pop_front()});
      end
   end
   initial begin
      repeat (5000) @(posedge clk_in);
      n_errors++;
      results();
   end
   // ****
   // Scenarios
   // ****
   initial begin
      r = $urandom(32'hea670efe);
      repeat (2) @(posedge clk_in);
      nrst_in <= 1'b1;
      rd(npic_pkg::NPIC_OP_GRP_GET, 8'h00, 32'h0);
      rd(npic_pkg::NPIC_OP_MASK_GET, 8'h00, 32'h0);
      rd(npic_pkg::NPIC_OP_VTOR_GET, 8'h00, 32'h0);
      rd(npic_pkg::NPIC_OP_IS_ENABLED, 8'h05, 32'h0);
      id = 8'($urandom_range(153));
      wr(npic_pkg::NPIC_OP_ENABLE, id, 32'h0);
      rd(npic_pkg::NPIC_OP_IS_ENABLED, id, 32'h1);
      wr(npic_pkg::NPIC_OP_DISABLE, id, 32'h0);
      rd(npic_pkg::NPIC_OP_IS_ENABLED, id, 32'h0);
      rd(npic_pkg::NPIC_OP_PRIO_GET, 8'hC8, 32'hFFFFFFFF);
      r = $urandom;
      wr(npic_pkg::NPIC_OP_PRIO_SET, id, r);
      rd(npic_pkg::NPIC_OP_PRIO_GET, id, {24'h0, r[7:0]});
      for (int g = 0; g < 9; g++) begin
         wr(npic_pkg::NPIC_OP_GRP_SET, 8'h00, 32'(g));
         rd(npic_pkg::NPIC_OP_GRP_GET, 8'h00, g > 3 ? 32'h3 : 32'(g));
         wr(npic_pkg::NPIC_OP_MASK_SET, 8'h00, 32'(g));
         rd(npic_pkg::NPIC_OP_MASK_GET, 8'h00, g > 7 ? 32'h7 : 32'(g));
      end
      r = $urandom;
      vtor = r & npic_pkg::VTOR_ALIGN_MASK;
      wr(npic_pkg::NPIC_OP_VTOR_SET, 8'h00, r);
      rd(npic_pkg::NPIC_OP_VTOR_GET, 8'h00, vtor);
      wr(npic_pkg::NPIC_OP_MASK_SET, 8'h00, 32'h0);
      // Sources 3 and 7 tie on level; only the ignored low bits differ
      foreach (src[i]) if (i inside {3, 7, 9, 11, 12}) begin
         wr(npic_pkg::NPIC_OP_PRIO_SET, 8'(i), i == 9 ? 32'h20 : i == 3 ? 32'h5F : 32'(i * 16 - 48));
         wr(npic_pkg::NPIC_OP_ENABLE, 8'(i), 32'h0);
      end
      idle(1);
      dly <= 2'($urandom_range(3));
      exp_id = '{8'h09, 8'h03, 8'h07};
      raise((154'h1 << 9) | (154'h1 << 3) | (154'h1 << 7));
      drained();
      wr(npic_pkg::NPIC_OP_MASK_SET, 8'h00, 32'h4);
      idle(1);
      exp_id = '{8'h09};
      raise((154'h1 << 9) | (154'h1 << 11));
      drained();
      exp_id = '{8'h0B};
      wr(npic_pkg::NPIC_OP_MASK_SET, 8'h00, 32'h0);
      drained();
      wr(npic_pkg::NPIC_OP_DISABLE, 8'h0C, 32'h0);
      wr(npic_pkg::NPIC_OP_PEND_SET, 8'h0C, 32'h0);
      drained();
      exp_id = '{8'h0C};
      wr(npic_pkg::NPIC_OP_ENABLE, 8'h0C, 32'h0);
      drained();
      wr(npic_pkg::NPIC_OP_DISABLE, 8'h0C, 32'h0);
      wr(npic_pkg::NPIC_OP_PEND_SET, 8'h0C, 32'h0);
      wr(npic_pkg::NPIC_OP_PEND_CLR, 8'h0C, 32'h0);
      wr(npic_pkg::NPIC_OP_ENABLE, 8'h0C, 32'h0);
      drained();
      rd(npic_pkg::NPIC_OP_GATE_CLOSE, 8'h00, 32'h0);
      rd(npic_pkg::NPIC_OP_GATE_CLOSE, 8'h00, 32'h1);
      wr(npic_pkg::NPIC_OP_PEND_SET, 8'h09, 32'h0);
      rd(npic_pkg::NPIC_OP_IS_ENABLED, 8'h09, 32'h1);
      drained();
      exp_id = '{8'h09};
      rd(npic_pkg::NPIC_OP_GATE_OPEN, 8'h00, 32'h1);
      drained();
      for (int g = 1; g < 4; g += 2) begin
         dly <= 2'($urandom_range(3));
         hold <= 1'b1;
         exp_id = '{8'h07};
         wr(npic_pkg::NPIC_OP_GRP_SET, 8'h00, 32'(g));
         wr(npic_pkg::NPIC_OP_PEND_SET, 8'h07, 32'h0);
         drained();
         if (g == 3) exp_id.push_back(8'h09);
         wr(npic_pkg::NPIC_OP_PEND_SET, 8'h09, 32'h0);
         drained();
         if (g == 1) exp_id.push_back(8'h09);
         hold <= 1'b0;
         drained();
      end
      results();
   end
endmodule
bind npic_top npic_assertions u_chk (.clk_in(clk_in), .nrst_in(nrst_in), .cmd_in(cmd_in), .cpu_ack_in(cpu_ack_in),
   .irq_out(irq_out), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out));
